// ===== hw/dcps_regs.svh
// Purpose: offsets, fields and counts of the diskette phase sequencer
// Assumes: byte-wide i/o space, primary decode
// Notes:   flow status bit layout follows the common controller convention
`ifndef DCPS_REGS_SVH
`define DCPS_REGS_SVH
`define DCPS_OFS_FLOW_STATUS    12'h3f4
`define DCPS_OFS_CMD_RESULT     12'h3f5
`define DCPS_FLOW_READY_BIT     7
`define DCPS_FLOW_TO_HOST_BIT   6
`define DCPS_FLOW_EXEC_BIT      5
`define DCPS_FLOW_BUSY_BIT      4
`define DCPS_STATUS_RESET       8'h80
// host-side ahb registers
`define DCPS_AHB_CTRL           32'h0000_0000
`define DCPS_AHB_STAT           32'h0000_0004
`define DCPS_AHB_DATA           32'h0000_0008
`define DCPS_AHB_RDATA          32'h0000_000c
// command encodings: {opcode, param count, result count, execution cycles}
`define DCPS_OP_READ            8'h06
`define DCPS_OP_WRITE           8'h05
`define DCPS_OP_SEEK            8'h0f
`define DCPS_OP_SPECIFY         8'h03
`define DCPS_OP_SENSE           8'h08
`define DCPS_EXEC_CYCLES        8'h10
`define DCPS_INT_CYCLES         8'h01
`define DCPS_PARAMS_XFER        8'h08
`define DCPS_PARAMS_SEEK        8'h02
`define DCPS_PARAMS_SPECIFY     8'h02
`define DCPS_RESULTS_XFER       8'h07
`define DCPS_RESULTS_SENSE      8'h02
// host command word fields
`define DCPS_FLD_IO_ADDR        19:8
`define DCPS_FLD_IO_BYTE        7:0
`define DCPS_FLD_DMA_BYTE       31:24
`define DCPS_BIT_IO_READ        0
`define DCPS_BIT_GRANT_EN       1
`endif

// ===== hw/dcps_pkg.sv
// Purpose: types shared by both ends of the diskette phase sequencer
// Assumes: nothing
// Notes:   gray-coded phase encoding
`default_nettype none
package dcps_pkg;
    typedef enum logic [1:0]
    {
        DCPS_IDLE    = 2'h0,
        DCPS_COMMAND = 2'h1,
        DCPS_EXECUTE = 2'h3,
        DCPS_RESULT  = 2'h2
    } dcps_phase_t;
    typedef enum logic [1:0]
    {
        DCPS_WORK_DATA = 2'h0,
        DCPS_WORK_MECH = 2'h1,
        DCPS_WORK_INT  = 2'h2
    } dcps_work_t;
endpackage
`default_nettype wire

// ===== hw/dcps_if.sv
// Purpose: i/o bus and dma channel two between host side and controller
// Assumes: one clock, byte-wide i/o cycles of one cycle
// Notes:   dma grant is active low
`default_nettype none
interface dcps_if (input wire logic hclk, input wire logic hresetn);
    logic [11:0] io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        dma_request_ch_two;
    logic        dma_grant_ch_two_n;
    logic [7:0]  dma_wdata;
    logic [7:0]  dma_rdata;
    modport ctrl
    (
        input  hclk, hresetn,
        input  io_addr, io_wr, io_rd, io_wdata, dma_grant_ch_two_n, dma_wdata,
        output io_rdata, dma_request_ch_two, dma_rdata
    );
    modport host
    (
        input  hclk, hresetn,
        output io_addr, io_wr, io_rd, io_wdata, dma_grant_ch_two_n, dma_wdata,
        input  io_rdata, dma_request_ch_two, dma_rdata
    );
endinterface
`default_nettype wire

// ===== hw/dcps_ctrl.sv
// Purpose: controller end: command, execution, result and idle phases
// Assumes: host polls flow status before every byte
// Notes:   execution work is modelled by counters, not a real drive
// Summary of operation
// - phases run command, execution, results in order
// - command bytes accepted one by one on data port
// - first byte opcode, rest are parameters
// - flow status shows readiness; host polls it
// - execution starts right after last command byte
// - execution does transfer, mechanical or internal work
// - data moves only by dma channel two
// - results read byte by byte from data port
// - commands without results return straight to idle
// - idle waits for first byte of command
`include "dcps_regs.svh"
`default_nettype none
module dcps_ctrl
    import dcps_pkg::*;
#(
    parameter int DMA_BYTES = 4
)
(
    dcps_if.ctrl       bus,
    output logic [1:0] phase,
    output logic [7:0] last_opcode,
    output logic       cmd_done
);
    // ****************************************************************
    // decode
    // ****************************************************************
    dcps_phase_t state;
    dcps_phase_t next_state;
    logic [7:0]  opcode;
    logic [7:0]  param_cnt;
    logic [7:0]  exec_cnt;
    logic [7:0]  result_idx;
    logic [7:0]  result_len;
    logic [7:0]  param_len;
    logic [7:0]  param0;
    dcps_work_t  work;
    logic        dma_pend;
    logic        grant;
    logic        wr_data;
    logic        rd_data;
    logic        rd_status;
    logic        cmd_last;
    logic        exec_end;
    logic        res_last;
    logic [7:0]  status_byte;
    logic [7:0]  result_byte;
    logic [7:0]  first_len;
    logic [7:0]  first_res;
    logic [7:0]  data_acc;
    logic [7:0]  cur_op;

    assign grant     = dma_pend && !bus.dma_grant_ch_two_n;
    assign wr_data   = bus.io_wr && bus.io_addr == `DCPS_OFS_CMD_RESULT;
    assign rd_data   = bus.io_rd && bus.io_addr == `DCPS_OFS_CMD_RESULT;
    assign rd_status = bus.io_rd && bus.io_addr == `DCPS_OFS_FLOW_STATUS;
    // opcode of the command being closed; a lone opcode byte is still on the bus
    assign cur_op    = (state == DCPS_IDLE) ? bus.io_wdata : opcode;

    // parameter and result counts per opcode
    assign first_len = (bus.io_wdata == `DCPS_OP_READ)    ? `DCPS_PARAMS_XFER :
                       (bus.io_wdata == `DCPS_OP_WRITE)   ? `DCPS_PARAMS_XFER :
                       (bus.io_wdata == `DCPS_OP_SEEK)    ? `DCPS_PARAMS_SEEK :
                       (bus.io_wdata == `DCPS_OP_SPECIFY) ? `DCPS_PARAMS_SPECIFY : 8'h00;
    assign first_res = (bus.io_wdata == `DCPS_OP_READ)    ? `DCPS_RESULTS_XFER :
                       (bus.io_wdata == `DCPS_OP_WRITE)   ? `DCPS_RESULTS_XFER :
                       (bus.io_wdata == `DCPS_OP_SENSE)   ? `DCPS_RESULTS_SENSE : 8'h00;

    assign cmd_last = (state == DCPS_IDLE && wr_data && first_len == 8'h00) ||
                      (state == DCPS_COMMAND && wr_data && param_cnt == param_len - 8'h01);
    assign exec_end = (work == DCPS_WORK_DATA) ? (!dma_pend && exec_cnt == 8'h00)
                                               : (exec_cnt == 8'h00);
    assign res_last = rd_data && result_idx == result_len - 8'h01;

    // flow status: ready, direction, execution, busy
    assign status_byte = (8'(state != DCPS_EXECUTE) << `DCPS_FLOW_READY_BIT)   |
                         (8'(state == DCPS_RESULT)  << `DCPS_FLOW_TO_HOST_BIT) |
                         (8'(state == DCPS_EXECUTE) << `DCPS_FLOW_EXEC_BIT)    |
                         (8'(state != DCPS_IDLE)    << `DCPS_FLOW_BUSY_BIT);
    assign result_byte = (result_idx == 8'h00) ? opcode :
                         (result_idx == 8'h01) ? param0 : data_acc ^ result_idx;

    // ****************************************************************
    // phase sequencer
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        case (state)
            DCPS_IDLE:
                if (wr_data)
                    next_state = cmd_last ? DCPS_EXECUTE : DCPS_COMMAND;
            DCPS_COMMAND:
                if (cmd_last)
                    next_state = DCPS_EXECUTE;
            DCPS_EXECUTE:
                if (exec_end)
                    next_state = (result_len == 8'h00) ? DCPS_IDLE : DCPS_RESULT;
            DCPS_RESULT:
                if (res_last)
                    next_state = DCPS_IDLE;
            default:
                next_state = DCPS_IDLE;
        endcase
    end

    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
            state <= DCPS_IDLE;
        else
            state <= next_state;
    end

    // ****************************************************************
    // command capture
    // ****************************************************************
    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            opcode     <= 8'h00;
            param_cnt  <= 8'h00;
            param_len  <= 8'h00;
            result_len <= 8'h00;
            param0     <= 8'h00;
        end
        else if (state == DCPS_IDLE && wr_data)
        begin
            opcode     <= bus.io_wdata;
            param0     <= 8'h00;
            param_len  <= first_len;
            result_len <= first_res;
            param_cnt  <= 8'h00;
        end
        else if (state == DCPS_COMMAND && wr_data)
        begin
            if (param_cnt == 8'h00)
                param0 <= bus.io_wdata;
            param_cnt <= param_cnt + 8'h01;
        end
    end

    // ****************************************************************
    // execution work
    // ****************************************************************
    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            work     <= DCPS_WORK_INT;
            exec_cnt <= 8'h00;
            dma_pend <= 1'b0;
            data_acc <= 8'h00;
        end
        else if (cmd_last)
        begin
            if (cur_op == `DCPS_OP_READ || cur_op == `DCPS_OP_WRITE)
            begin
                work     <= DCPS_WORK_DATA;
                exec_cnt <= 8'(DMA_BYTES);
                dma_pend <= 1'b1;
            end
            else if (cur_op == `DCPS_OP_SEEK)
            begin
                work     <= DCPS_WORK_MECH;
                exec_cnt <= `DCPS_EXEC_CYCLES;
            end
            else
            begin
                work     <= DCPS_WORK_INT;
                exec_cnt <= `DCPS_INT_CYCLES;
            end
            data_acc <= 8'h00;
        end
        else if (state == DCPS_EXECUTE)
        begin
            if (work == DCPS_WORK_DATA)
            begin
                if (grant)
                begin
                    data_acc <= data_acc + bus.dma_wdata;
                    exec_cnt <= exec_cnt - 8'h01;
                    if (exec_cnt == 8'h01)
                        dma_pend <= 1'b0;
                end
            end
            else if (exec_cnt != 8'h00)
                exec_cnt <= exec_cnt - 8'h01;
        end
    end

    // ****************************************************************
    // results and outputs
    // ****************************************************************
    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
            result_idx <= 8'h00;
        else if (state == DCPS_EXECUTE)
            result_idx <= 8'h00;
        else if (state == DCPS_RESULT && rd_data)
            result_idx <= result_idx + 8'h01;
    end

    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            bus.io_rdata  <= `DCPS_STATUS_RESET;
            bus.dma_rdata <= 8'h00;
            last_opcode   <= 8'h00;
            cmd_done      <= 1'b0;
        end
        else
        begin
            if (rd_status)
                bus.io_rdata <= status_byte;
            else if (rd_data)
                bus.io_rdata <= (state == DCPS_RESULT) ? result_byte : 8'h00;
            bus.dma_rdata <= data_acc ^ exec_cnt;
            cmd_done      <= state == DCPS_EXECUTE && exec_end;
            if (cmd_last)
                last_opcode <= cur_op;
        end
    end

    assign bus.dma_request_ch_two = dma_pend && state == DCPS_EXECUTE;
    assign phase = state;
endmodule // dcps_ctrl
`default_nettype wire

// ===== hw/dcps_host.sv
// Purpose: host end: ahb-lite command port driving i/o cycles and dma grant
// Assumes: single word transfers, always okay
// Notes:   software polls flow status before each byte
`include "dcps_regs.svh"
`default_nettype none
module dcps_host
    import dcps_pkg::*;
(
    dcps_if.host              bus,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp
);
    // ****************************************************************
    // ahb decode
    // ****************************************************************
    logic        ph_wr;
    logic [31:0] ph_addr;
    logic [31:0] rd_word;
    logic        grant_en;
    logic [7:0]  io_captured;
    logic [7:0]  dma_byte;
    logic        rd_pend;
    wire         take = hsel && hready && htrans[1];

    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            ph_wr   <= 1'b0;
            hrdata  <= 32'h0;
            ph_addr <= 32'h0;
        end
        else
        begin
            ph_wr   <= take && hwrite;
            hrdata  <= (take && !hwrite) ? rd_word : 32'h0;
            ph_addr <= haddr;
        end
    end

    // io cycle: data write goes to port, status/data read issues io read
    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            bus.io_addr  <= 12'h000;
            bus.io_wr    <= 1'b0;
            bus.io_rd    <= 1'b0;
            bus.io_wdata <= 8'h00;
            grant_en     <= 1'b0;
            dma_byte     <= 8'h00;
            rd_pend      <= 1'b0;
            io_captured  <= 8'h00;
        end
        else
        begin
            bus.io_wr <= 1'b0;
            bus.io_rd <= 1'b0;
            rd_pend   <= bus.io_rd;
            if (rd_pend)
                io_captured <= bus.io_rdata;
            if (ph_wr && ph_addr == `DCPS_AHB_DATA)
            begin
                bus.io_addr  <= hwdata[`DCPS_FLD_IO_ADDR];
                bus.io_wdata <= hwdata[`DCPS_FLD_IO_BYTE];
                bus.io_wr    <= 1'b1;
            end
            else if (ph_wr && ph_addr == `DCPS_AHB_CTRL)
            begin
                bus.io_addr <= hwdata[`DCPS_FLD_IO_ADDR];
                bus.io_rd   <= hwdata[`DCPS_BIT_IO_READ];
                grant_en    <= hwdata[`DCPS_BIT_GRANT_EN];
                dma_byte    <= hwdata[`DCPS_FLD_DMA_BYTE];
            end
        end
    end

    // dma controller: grant held low as long as the request is asserted and grant is enabled
    assign bus.dma_grant_ch_two_n = !(grant_en && bus.dma_request_ch_two);
    assign bus.dma_wdata = dma_byte;

    // ****************************************************************
    // read data and response
    // ****************************************************************
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    // read word chosen in the address phase, registered into the data phase
    assign rd_word   = (haddr == `DCPS_AHB_STAT)  ? {23'h0, bus.dma_request_ch_two, 8'h0} :
                       (haddr == `DCPS_AHB_RDATA) ? {16'h0, bus.dma_rdata, io_captured} :
                       (haddr == `DCPS_AHB_CTRL)  ? {30'h0, grant_en, 1'b0} : 32'h0;
endmodule // dcps_host
`default_nettype wire

// ===== dv/dcps_assertions.sv
// Purpose: concurrent checks on the io link and phase of the sequencer
// Assumes: one clock, reset asynchronous and active low
// Notes:   sees io address, strobes and read data, the dma request, the controller phase and cmd_done only
`include "dcps_regs.svh"
`default_nettype none
module dcps_assertions
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [11:0] io_addr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_wr,
    input wire logic        dma_request_ch_two,
    input wire logic [1:0]  phase,
    input wire logic        cmd_done
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire st_rd = io_rd && io_addr == `DCPS_OFS_FLOW_STATUS;
    wire dp_rd = io_rd && io_addr == `DCPS_OFS_CMD_RESULT;
    wire dp_wr = io_wr && io_addr == `DCPS_OFS_CMD_RESULT;
    a_req_in_exec: assert property (dma_request_ch_two |-> phase == 2'h3)
        else $error("dma request outside execution");
    a_phase_order: assert property ($changed(phase) |->
        ($past(phase) == 2'h0 && phase != 2'h2) || ($past(phase) == 2'h1 && phase == 2'h3)
        || ($past(phase) == 2'h3 && phase != 2'h1) || ($past(phase) == 2'h2 && phase == 2'h0))
        else $error("phase step out of order");
    a_idle_ready: assert property (st_rd && phase == 2'h0 |=> io_rdata[7:6] == 2'h2)
        else $error("idle status not ready");
    a_exec_flags: assert property (st_rd && phase == 2'h3 |=> io_rdata[7:5] == 3'h1)
        else $error("execution status wrong");
    a_result_flag: assert property (st_rd && phase == 2'h2 |=> io_rdata[7:6] == 2'h3)
        else $error("result status wrong");
    a_first_byte: assert property (dp_wr && phase == 2'h0 |=> phase != 2'h0)
        else $error("first byte left controller idle");
    a_dp_quiet: assert property (dp_rd && phase != 2'h2 |=> io_rdata == 8'h00)
        else $error("data port read outside results");
    a_done_exec: assert property (cmd_done |-> $past(phase) == 2'h3 || phase == 2'h3)
        else $error("done pulse outside execution");
endmodule // dcps_assertions
`default_nettype wire

// ===== dv/diskette_ctrl_phase_sequencer_tb.sv
// Purpose: drives commands through the ahb host end into the controller
// Assumes: 20 MHz clock, hreadyout answers every request
// Notes:   results modelled from opcode, first parameter and dma byte sum
`include "dcps_regs.svh"
`default_nettype none
module diskette_ctrl_phase_sequencer_tb
    import dcps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // harness
    // ****************************************
    logic        hclk = 1'b0;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire  [1:0]  phase;
    wire  [7:0]  last_op;
    wire         cmd_done;
    int          miscompares = 0;
    int          checked = 0;
    int          cyc = 0;
    localparam int DMA_N = 4;
    always #25 hclk = ~hclk;
    dcps_if bus_if (.hclk(hclk), .hresetn(hresetn));
    dcps_ctrl #(.DMA_BYTES(DMA_N)) dcps_ctrl_inst (.bus(bus_if), .phase(phase),
        .last_opcode(last_op), .cmd_done(cmd_done));
    dcps_host dcps_host_inst (.bus(bus_if), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    dcps_assertions dcps_assertions_inst (.hclk(hclk), .hresetn(hresetn),
        .io_addr(bus_if.io_addr), .io_rd(bus_if.io_rd), .io_rdata(bus_if.io_rdata),
        .io_wr(bus_if.io_wr), .dma_request_ch_two(bus_if.dma_request_ch_two),
        .phase(phase), .cmd_done(cmd_done));
    task automatic conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        r = hrdata;
    endtask
    task automatic rd_io(input logic [11:0] a, output logic [7:0] b);
        logic [31:0] r;
        ahb(1'b1, `DCPS_AHB_CTRL, {12'h000, a, 8'h01}, r);
        repeat (3) @(posedge hclk);
        ahb(1'b0, `DCPS_AHB_RDATA, 32'h0, r);
        b = r[7:0];
    endtask
    task automatic wr_io(input logic [11:0] a, input logic [7:0] b);
        logic [31:0] r;
        ahb(1'b1, `DCPS_AHB_DATA, {12'h000, a, b}, r);
    endtask
    // ****************************************
    // command model and sequence
    // ****************************************
    task automatic run(input logic [7:0] op, input int np, input int nr);
        logic [7:0]  s;
        logic [7:0]  b;
        logic [31:0] r;
        logic [7:0]  exp[$];
        logic [7:0]  d;
        int          n;
        int          acc;
        acc = 0;
        exp = {op};
        for (int i = 0; i <= np; i++)
        begin
            rd_io(`DCPS_OFS_FLOW_STATUS, s);
            chk("ready", 1'b1, s[7]);
            if (i > 0) chk("phase", 2'h1, phase);
            b = (i == 0) ? op : 8'($urandom);
            if (i == 1) exp.push_back(b);
            wr_io(`DCPS_OFS_CMD_RESULT, b);
        end
        if (np == 0) exp.push_back(8'h00);
        if (op == `DCPS_OP_READ || op == `DCPS_OP_WRITE)
        begin
            n = 0;
            do ahb(1'b0, `DCPS_AHB_STAT, 32'h0, r); while (!r[8] && ++n < 40);
            chk("dma request", 1'b1, r[8]);
            chk("exec phase", 2'h3, phase);
            d = 8'($urandom);
            acc = DMA_N * d;
            ahb(1'b1, `DCPS_AHB_CTRL, {d, 24'h000002}, r);
            n = 0;
            do ahb(1'b0, `DCPS_AHB_STAT, 32'h0, r); while (r[8] && ++n < 40);
            chk("dma drained", 1'b0, r[8]);
            ahb(1'b1, `DCPS_AHB_CTRL, 32'h0, r);
        end
        for (int j = 2; j < nr; j++)
            exp.push_back(8'(acc) ^ 8'(j));
        n = 0;
        for (int k = 0; k < 60; k++)
        begin
            rd_io(`DCPS_OFS_FLOW_STATUS, s);
            if (s[7:6] == 2'h2) break;
            if (s[7:6] == 2'h3)
            begin
                rd_io(`DCPS_OFS_CMD_RESULT, b);
                if (n < exp.size()) chk("result", exp[n], b);
                n++;
            end
        end
        chk("result count", nr, n);
        chk("idle", 2'h0, phase);
        chk("opcode", op, last_op);
    endtask
    logic [7:0] ops[5] = '{`DCPS_OP_READ, `DCPS_OP_WRITE, `DCPS_OP_SEEK,
        `DCPS_OP_SPECIFY, `DCPS_OP_SENSE};
    int nps[5] = '{8, 8, 2, 2, 0};
    int nrs[5] = '{7, 7, 0, 0, 2};
    initial
    begin
        logic [7:0] s;
        logic [7:0] o;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        o = 8'($urandom(39));
        rd_io(`DCPS_OFS_FLOW_STATUS, s);
        chk("reset status", `DCPS_STATUS_RESET, s);
        rd_io(`DCPS_OFS_CMD_RESULT, s);
        chk("idle data read", 8'h00, s);
        for (int i = 0; i < 5; i++)
            run(ops[i], nps[i], nrs[i]);
        do o = 8'($urandom); while (o inside {ops});
        run(o, 0, 0);
        rd_io(`DCPS_OFS_FLOW_STATUS, s);
        wr_io(`DCPS_OFS_CMD_RESULT, `DCPS_OP_SEEK);
        rd_io(`DCPS_OFS_FLOW_STATUS, s);
        wr_io(`DCPS_OFS_CMD_RESULT, 8'h5a);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd_io(`DCPS_OFS_FLOW_STATUS, s);
        chk("mid reset status", `DCPS_STATUS_RESET, s);
        chk("mid reset phase", 2'h0, phase);
        run(`DCPS_OP_SENSE, 0, 2);
        conclude();
    end
endmodule // diskette_ctrl_phase_sequencer_tb
`default_nettype wire
